// ==== logic/pdr_pkg.sv ====
`default_nettype none
package pdr_pkg;

   // ------------------------------------------------------------
   // Memory pages
   // ------------------------------------------------------------
   localparam int PAGE_BYTES = 1024;
   localparam logic [5:0] PAGE_ROM0 = 6'h30; // C000-C3FF
   localparam logic [5:0] PAGE_ROM1 = 6'h31; // C400-C7FF
   localparam logic [5:0] PAGE_SYSRAM = 6'h32; // C800-CBFF
   localparam logic [5:0] PAGE_SCREEN = 6'h33; // CC00-CFFF
   localparam int PAGE_ROM0_IX = 0;
   localparam int PAGE_ROM1_IX = 1;
   localparam int PAGE_SYSRAM_IX = 2;
   localparam int PAGE_SCREEN_IX = 3;

   // ------------------------------------------------------------
   // Port numbers, high address byte
   // ------------------------------------------------------------
   localparam logic [7:0] PORT_KBD_STAT = 8'hFA;
   localparam logic [7:0] PORT_KBD_DATA = 8'hFC;
   localparam logic [7:0] PORT_SER_STAT = 8'hF8;
   localparam logic [7:0] PORT_SER_DATA = 8'hF9;
   localparam logic [7:0] PORT_TAPE_STAT = 8'hF6;
   localparam logic [7:0] PORT_TAPE_DATA = 8'hF7;
   localparam logic [7:0] PORT_PARALLEL = 8'hFD;
   localparam logic [7:0] PORT_SENSE = 8'hFF;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_PAR_OUT = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam int IRQ_PAR_WR = 0;
   localparam int IRQ_SER_TX = 1;
   localparam int IRQ_KBD_RD = 2;
   localparam int IRQ_REFRESH_LOST = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_KBD, SEL_PAR, SEL_SHARED, SEL_INT
   } pdr_src_e;

   typedef struct packed {
      logic [15:0] addr;
      logic mem;
      logic io;
      logic rd;
      logic wr;
   } pdr_cpu_s;

   typedef struct packed {
      logic kbd_stat_rd;
      logic kbd_data_rd;
      logic par_rd;
      logic par_wr;
      logic sense_rd;
      logic ser_en;
      logic ser_stat_rd;
      logic ser_data_rd;
      logic ser_data_wr;
      logic tape_en;
      logic tape_stat_rd;
      logic tape_data_rd;
      logic tape_data_wr;
   } pdr_strobe_s;

endpackage
`default_nettype wire

// ==== logic/pdr_router.sv ====
// Operation
// - Four adjoining 1024-byte pages, own selects
// - ROM page zero: C000 to C3FF
// - ROM page one: C400 to C7FF
// - System RAM page: C800 to CBFF
// - Screen page: CC00 to CFFF
// - Pages decoded from six top address bits
// - Ports decoded from eight top bits
// - Processor beats screen refresh on screen memory
// - Parallel write latches shared bus to connector
// - Parallel inputs feed multiplexer unlatched
// - Keyboard lines direct; ready flag internal
// - Sense strobe drives switches onto shared bus
// - Serial UART enabled by strobe, status internal
// - Tape UART enabled by strobe, status internal
// - Serial data write strobe loads transmitter
// - Keyboard read picks keyboard; serial picks internal
// - Multiplexer chooses among four sources
// - ROM/RAM read internal; RAM writes shared
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pdr_router (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   // Processor side
   input wire pdr_pkg::pdr_cpu_s cpu_bus,
   input wire logic [7:0] cpu_data_out,
   output logic [7:0] cpu_data_in,
   output var pdr_pkg::pdr_src_e data_in_sel,
   output logic ext_drv_en,
   // Memory pages and ports
   output logic [3:0] page_sel,
   output var pdr_pkg::pdr_strobe_s port_strobe,
   input wire logic [7:0] internal_bus,
   input wire logic [7:0] keyboard_char_lines,
   input wire logic [7:0] parallel_in_lines,
   input wire logic [7:0] sense_switches,
   output logic [7:0] parallel_out_port,
   input wire logic refresh_req,
   output logic refresh_grant,
   // Shared two-way bus, oe low while driving
   input wire logic [7:0] shared_two_way_bus_i,
   output logic [7:0] shared_two_way_bus_o,
   output logic shared_two_way_bus_oe_n
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int CPU_W = $bits(pdr_pkg::pdr_cpu_s);
   localparam int PIN_W = 8 * 6 + 1;
   pdr_pkg::pdr_cpu_s s_cpu;
   logic [7:0] s_wdata, s_int, s_kbd, s_par, s_sense, s_shared;
   logic s_refresh;

   pdr_sync #(.WIDTH(CPU_W)) u_sync_cpu (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(cpu_bus),
      .dout(s_cpu)
   );

   pdr_sync #(.WIDTH(PIN_W)) u_sync_pins (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({cpu_data_out, internal_bus, keyboard_char_lines,
            parallel_in_lines, sense_switches, shared_two_way_bus_i,
            refresh_req}),
      .dout({s_wdata, s_int, s_kbd, s_par, s_sense, s_shared,
             s_refresh})
   );

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [31:0] ctrl;
   logic en;
   logic [3:0] next_page;
   pdr_pkg::pdr_strobe_s next_strobe;
   pdr_pkg::pdr_src_e next_sel;
   logic [7:0] port;
   logic io_ok;

   assign en = ctrl[pdr_pkg::CTRL_EN_BIT];
   assign port = s_cpu.addr[15:8];
   // Port cycles only when no memory cycle is flagged
   assign io_ok = en && s_cpu.io && !s_cpu.mem;

   // Page selects from the top six address bits
   always_comb begin
      next_page = 4'h0;
      if (en && s_cpu.mem && !s_cpu.io) begin
         case (s_cpu.addr[15:10])
            pdr_pkg::PAGE_ROM0: next_page[pdr_pkg::PAGE_ROM0_IX] = 1'b1;
            pdr_pkg::PAGE_ROM1: next_page[pdr_pkg::PAGE_ROM1_IX] = 1'b1;
            pdr_pkg::PAGE_SYSRAM:
               next_page[pdr_pkg::PAGE_SYSRAM_IX] = 1'b1;
            pdr_pkg::PAGE_SCREEN:
               next_page[pdr_pkg::PAGE_SCREEN_IX] = 1'b1;
            default: next_page = 4'h0;
         endcase
      end
   end

   // Port strobes from the top eight address bits
   always_comb begin
      next_strobe = '0;
      if (io_ok) begin
         case (port)
            pdr_pkg::PORT_KBD_STAT: next_strobe.kbd_stat_rd = s_cpu.rd;
            pdr_pkg::PORT_KBD_DATA: next_strobe.kbd_data_rd = s_cpu.rd;
            pdr_pkg::PORT_PARALLEL: begin
               next_strobe.par_rd = s_cpu.rd;
               next_strobe.par_wr = s_cpu.wr;
            end
            pdr_pkg::PORT_SENSE: next_strobe.sense_rd = s_cpu.rd;
            pdr_pkg::PORT_SER_STAT: begin
               next_strobe.ser_stat_rd = s_cpu.rd;
            end
            pdr_pkg::PORT_SER_DATA: begin
               next_strobe.ser_data_rd = s_cpu.rd;
               next_strobe.ser_data_wr = s_cpu.wr;
            end
            pdr_pkg::PORT_TAPE_STAT: next_strobe.tape_stat_rd = s_cpu.rd;
            pdr_pkg::PORT_TAPE_DATA: begin
               next_strobe.tape_data_rd = s_cpu.rd;
               next_strobe.tape_data_wr = s_cpu.wr;
            end
            default: next_strobe = '0;
         endcase
      end
      next_strobe.ser_en = next_strobe.ser_stat_rd |
         next_strobe.ser_data_rd | next_strobe.ser_data_wr;
      next_strobe.tape_en = next_strobe.tape_stat_rd |
         next_strobe.tape_data_rd | next_strobe.tape_data_wr;
   end

   // Input multiplexer source for this cycle
   always_comb begin
      next_sel = pdr_pkg::SEL_SHARED; // external memory and I/O
      if (next_strobe.kbd_data_rd)
         next_sel = pdr_pkg::SEL_KBD;
      else if (next_strobe.par_rd)
         next_sel = pdr_pkg::SEL_PAR;
      else if (next_strobe.kbd_stat_rd | next_strobe.ser_stat_rd |
               next_strobe.ser_data_rd | next_strobe.tape_stat_rd |
               next_strobe.tape_data_rd)
         next_sel = pdr_pkg::SEL_INT;
      else if (|next_page[pdr_pkg::PAGE_SYSRAM_IX:0] && s_cpu.rd)
         next_sel = pdr_pkg::SEL_INT;
   end

   // ------------------------------------------------------------
   // Selects, strobes and data paths
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page_sel <= 4'h0;
         port_strobe <= '0;
         data_in_sel <= pdr_pkg::SEL_SHARED;
         ext_drv_en <= 1'b0;
      end else begin
         page_sel <= next_page;
         port_strobe <= next_strobe;
         data_in_sel <= next_sel;
         ext_drv_en <= s_cpu.rd && next_sel == pdr_pkg::SEL_SHARED;
      end
   end

   // Four-input multiplexer into the processor
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_data_in <= 8'h00;
      end else begin
         case (next_sel)
            pdr_pkg::SEL_KBD: cpu_data_in <= s_kbd;
            pdr_pkg::SEL_PAR: cpu_data_in <= s_par;
            pdr_pkg::SEL_INT: cpu_data_in <= s_int;
            default: cpu_data_in <= s_shared;
         endcase
      end
   end

   // Shared bus: processor writes and sense switch reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_two_way_bus_o <= 8'h00;
         shared_two_way_bus_oe_n <= 1'b1;
      end else if (s_cpu.wr && (s_cpu.mem || s_cpu.io)) begin
         shared_two_way_bus_o <= s_wdata;
         shared_two_way_bus_oe_n <= 1'b0;
      end else if (next_strobe.sense_rd) begin
         shared_two_way_bus_o <= s_sense;
         shared_two_way_bus_oe_n <= 1'b0;
      end else begin
         shared_two_way_bus_oe_n <= 1'b1;
      end
   end

   // Parallel output latch holds the strobed bus value
   always_ff @(posedge aclk) begin
      if (!aresetn)
         parallel_out_port <= 8'h00;
      else if (port_strobe.par_wr)
         parallel_out_port <= shared_two_way_bus_o;
   end

   // Screen refresh gets the memory only when the processor is off it
   always_ff @(posedge aclk) begin
      if (!aresetn)
         refresh_grant <= 1'b0;
      else
         refresh_grant <= s_refresh &&
            !next_page[pdr_pkg::PAGE_SCREEN_IX];
   end

   // ------------------------------------------------------------
   // Interrupt events
   // ------------------------------------------------------------
   logic [3:0] irq_stat, irq_mask, events;
   logic stat_rd;

   assign events = {s_refresh && next_page[pdr_pkg::PAGE_SCREEN_IX],
                    next_strobe.kbd_data_rd, next_strobe.ser_data_wr,
                    next_strobe.par_wr};

   // Sticky bits, cleared by a read; a new event wins the clear
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_stat <= 4'h0;
      else
         irq_stat <= (stat_rd ? 4'h0 : irq_stat) | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(((stat_rd ? 4'h0 : irq_stat) | events) & irq_mask);
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_wr;

   assign do_wr = aw_held && w_held && !s_axi_bvalid;
   assign aw_held = !s_axi_awready; // Ready flops double as held flags
   assign w_held = !s_axi_wready;

   // Address and data captured in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end else if (do_wr) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_wr) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Register writes and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= pdr_pkg::CTRL_RESET;
         irq_mask <= pdr_pkg::IRQ_MASK_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pdr_pkg::RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= pdr_pkg::RESP_OKAY;
         case (aw_addr)
            pdr_pkg::REG_CTRL: begin
               if (w_strb[0])
                  ctrl[7:0] <= w_data[7:0];
            end
            pdr_pkg::REG_IRQ_MASK: begin
               if (w_strb[0])
                  irq_mask <= w_data[3:0];
            end
            pdr_pkg::REG_STATUS, pdr_pkg::REG_IRQ_STAT,
            pdr_pkg::REG_PAR_OUT: s_axi_bresp <= pdr_pkg::RESP_OKAY;
            default: s_axi_bresp <= pdr_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign stat_rd = s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == pdr_pkg::REG_IRQ_STAT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pdr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pdr_pkg::RESP_OKAY;
         case (s_axi_araddr)
            pdr_pkg::REG_CTRL: s_axi_rdata <= {24'h0, ctrl[7:0]};
            pdr_pkg::REG_STATUS:
               s_axi_rdata <= {24'h0, refresh_grant, ext_drv_en,
                               data_in_sel, page_sel};
            pdr_pkg::REG_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
            pdr_pkg::REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
            pdr_pkg::REG_PAR_OUT: s_axi_rdata <= {24'h0, parallel_out_port};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= pdr_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_ROM0: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && s_cpu.mem && !s_cpu.io && s_cpu.addr[15:10] == 6'h30)
      |=> page_sel == 4'h1)
      else $error("ROM page zero not selected");
   AST_ROM1: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && s_cpu.mem && !s_cpu.io && s_cpu.addr[15:10] == 6'h31)
      |=> page_sel == 4'h2)
      else $error("ROM page one not selected");
   AST_SYSRAM: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && s_cpu.mem && !s_cpu.io && s_cpu.addr[15:10] == 6'h32)
      |=> page_sel == 4'h4)
      else $error("System RAM page not selected");
   AST_SCREEN: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && s_cpu.mem && !s_cpu.io && s_cpu.addr[15:10] == 6'h33)
      |=> page_sel == 4'h8)
      else $error("Screen page not selected");
   AST_ONE_PAGE: assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot0(page_sel) and (s_cpu.addr[15:12] != 4'hC |=> page_sel == 4'h0))
      else $error("Page selects overlap or stray");
   AST_NO_MIX: assert property (@(posedge aclk) disable iff (!aresetn)
      !(|page_sel && |port_strobe))
      else $error("Page select with port strobe");
   AST_REFRESH: assert property (@(posedge aclk) disable iff (!aresetn)
      page_sel[3] |-> !refresh_grant)
      else $error("Refresh granted during processor access");
   AST_PAR_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      port_strobe.par_wr |=> parallel_out_port == $past(shared_two_way_bus_o)
      ##1 parallel_out_port == $past(parallel_out_port, 1) ||
      $past(port_strobe.par_wr))
      else $error("Parallel output not latched");
   AST_SENSE: assert property (@(posedge aclk) disable iff (!aresetn)
      (next_strobe.sense_rd && !s_cpu.wr) |=> (port_strobe.sense_rd &&
      !shared_two_way_bus_oe_n && shared_two_way_bus_o == $past(s_sense)))
      else $error("Sense switches not driven");
   AST_KBD_MUX: assert property (@(posedge aclk) disable iff (!aresetn)
      next_strobe.kbd_data_rd |=> data_in_sel == pdr_pkg::SEL_KBD &&
      cpu_data_in == $past(s_kbd))
      else $error("Keyboard read not steered");
   AST_SER_MUX: assert property (@(posedge aclk) disable iff (!aresetn)
      next_strobe.ser_data_rd |=> data_in_sel == pdr_pkg::SEL_INT &&
      port_strobe.ser_en && cpu_data_in == $past(s_int))
      else $error("Serial read not steered internal");
   AST_PAR_IN: assert property (@(posedge aclk) disable iff (!aresetn)
      next_strobe.par_rd |=> cpu_data_in == $past(s_par))
      else $error("Parallel input not passed through");
   AST_TX_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
      port_strobe.ser_data_wr |-> port_strobe.ser_en &&
      !shared_two_way_bus_oe_n)
      else $error("Transmit load without bus data");
   AST_TAPE: assert property (@(posedge aclk) disable iff (!aresetn)
      next_strobe.tape_stat_rd |=> port_strobe.tape_en &&
      data_in_sel == pdr_pkg::SEL_INT)
      else $error("Tape status not internal");

endmodule // pdr_router
`default_nettype wire

// ==== logic/pdr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pin inputs
module pdr_sync #(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // First stage read only by second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // pdr_sync
`default_nettype wire

// ==== verif/pdr_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Processor side of the decoder, one bus cycle at a time
// ------------------------------------------------------------
module pdr_cpu_model (
   input wire logic aclk,
   output var pdr_pkg::pdr_cpu_s cpu_bus,
   output var logic [7:0] cpu_data_out
);
   initial begin
      cpu_bus = '0;
      cpu_data_out = 8'h00;
   end
   // Hold one cycle type long enough for the synchronised decode
   task automatic cyc(input logic [15:0] a, input logic [3:0] k,
         input logic [7:0] d);
      cpu_bus <= {a, k};
      cpu_data_out <= k[0] ? d : ~cpu_data_out; // Stale data is scrambled
      repeat (8) @(posedge aclk); // Sense data returns via shared bus
   endtask
   // Drop every strobe between cycles
   task automatic idle();
      cpu_bus <= {cpu_bus.addr, 4'h0};
      cpu_data_out <= ~cpu_data_out;
      repeat (6) @(posedge aclk);
   endtask
   // Status read always comes before the transmit write
   task automatic tx(input logic [7:0] d);
      cyc({pdr_pkg::PORT_SER_STAT, 8'h00}, 4'b0110, 8'h00);
      cyc({pdr_pkg::PORT_SER_DATA, 8'h00}, 4'b0101, d);
   endtask
endmodule // pdr_cpu_model
`default_nettype wire

// ==== verif/tb_pdr_router.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_pdr_router;
   localparam logic [3:0] MRD = 4'b1010;
   localparam logic [3:0] IRD = 4'b0110;
   localparam logic [3:0] IWR = 4'b0101;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, ext_en, oe_n, grant;
   logic [1:0] bresp, rresp, rs;
   pdr_pkg::pdr_cpu_s cpu_bus;
   pdr_pkg::pdr_src_e src;
   pdr_pkg::pdr_strobe_s stb;
   logic [7:0] dout, din, par_out, sh_o, sh_i;
   logic [3:0] page;
   logic [7:0] intv = 8'hC3, kbv = 8'h4B, piv = 8'h96, ssv = 8'h7E;
   logic [7:0] ext = 8'h5A;
   logic rfq = 1'b0;
   int bad_count = 0;
   int comparisons = 0;
   logic [15:0] pa [10] = '{16'hC000, 16'hC3FF, 16'hC400, 16'hC7FF,
      16'hC800, 16'hCBFF, 16'hCC00, 16'hCFFF, 16'hBFFF, 16'hD000};
   logic [3:0] pe [10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8,
      4'h0, 4'h0};
   logic [7:0] pp [8] = '{8'hFA, 8'hFC, 8'hFD, 8'hFF, 8'hF8, 8'hF9, 8'hF6,
      8'hF7};
   int pb [8] = '{12, 11, 10, 8, 6, 5, 2, 1};

   // Clock and the shared wire, far side drives when device is off
   always #4 aclk = ~aclk;
   assign sh_i = oe_n ? ext : sh_o;

   pdr_router uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq), .cpu_bus(cpu_bus),
      .cpu_data_out(dout), .cpu_data_in(din), .data_in_sel(src),
      .ext_drv_en(ext_en), .page_sel(page), .port_strobe(stb),
      .internal_bus(intv), .keyboard_char_lines(kbv),
      .parallel_in_lines(piv), .sense_switches(ssv),
      .parallel_out_port(par_out), .refresh_req(rfq),
      .refresh_grant(grant), .shared_two_way_bus_i(sh_i),
      .shared_two_way_bus_o(sh_o), .shared_two_way_bus_oe_n(oe_n));
   pdr_cpu_model cpu (.aclk(aclk), .cpu_bus(cpu_bus),
      .cpu_data_out(dout));

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h got %h", n, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_rd(pdr_pkg::REG_CTRL);
      chk("ctrl", 32'h1, rd);
      axi_rd(pdr_pkg::REG_IRQ_MASK);
      chk("mask", 32'h0, rd);
      axi_rd(8'h40);
      chk("bad_rresp", pdr_pkg::RESP_SLVERR, rs);
      chk("bad_rdata", 32'h0, rd);
      axi_wr(8'h40, 32'h1);
      chk("bad_bresp", pdr_pkg::RESP_SLVERR, rs);
      $display("test registers done");
      for (int i = 0; i < 10; i++) begin
         cpu.cyc(pa[i], MRD, 8'h00);
         chk("page_sel", pe[i], page);
         chk("mux_src", (i < 6) ? 3 : 2, src);
         chk("cpu_din", (i < 6) ? intv : ext, din);
         chk("ext_drv", i >= 6, ext_en);
      end
      cpu.cyc(16'hC800, 4'b1001, 8'h33);
      chk("ram_wr", 8'h33, sh_i);
      $display("test pages done");
      for (int i = 0; i < 8; i++) begin
         cpu.cyc({pp[i], 8'h00}, IRD, 8'h00);
         chk("strobe", 1, stb[pb[i]]);
         chk("no_page", 0, page);
         chk("mux_src", (i == 1) ? 0 : (i == 2) ? 1 : (i == 3) ? 2 : 3,
            src);
         chk("cpu_din", (i == 1) ? kbv : (i == 2) ? piv : (i == 3) ? ssv :
            intv, din);
         if (i > 3)
            chk("uart_en", 1, stb[(i < 6) ? 7 : 3]);
      end
      cpu.cyc({pdr_pkg::PORT_PARALLEL, 8'h00}, IRD, 8'h00);
      piv <= 8'h3C;
      repeat (4) @(posedge aclk);
      chk("par_live", 8'h3C, din);
      $display("test ports done");
      cpu.cyc(16'hFD00, IWR, 8'hA5);
      chk("par_wr", 1, stb.par_wr);
      chk("par_out", 8'hA5, par_out);
      cpu.idle();
      chk("par_hold", 8'hA5, par_out);
      chk("irq_masked", 0, irq);
      axi_wr(pdr_pkg::REG_IRQ_MASK, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq_on", 1, irq);
      axi_rd(pdr_pkg::REG_IRQ_STAT);
      chk("irq_stat", 1, rd[0]);
      repeat (2) @(posedge aclk);
      chk("irq_off", 0, irq);
      axi_rd(pdr_pkg::REG_PAR_OUT);
      chk("par_reg", 32'hA5, rd);
      $display("test parallel done");
      cpu.tx(8'h41);
      chk("ser_wr", 1, stb.ser_data_wr);
      chk("tx_byte", 8'h41, sh_i);
      cpu.cyc({pdr_pkg::PORT_TAPE_DATA, 8'h00}, IWR, 8'h5C);
      chk("tape_wr", 2'b11, {stb.tape_en, stb.tape_data_wr});
      cpu.cyc(16'hC000, 4'b1110, 8'h00);
      chk("mix_page", 0, page);
      chk("mix_stb", 0, stb);
      axi_wr(pdr_pkg::REG_CTRL, 32'h0);
      cpu.cyc(16'hC000, MRD, 8'h00);
      chk("ctrl_off", 0, page);
      axi_wr(pdr_pkg::REG_CTRL, 32'h1);
      rfq <= 1'b1;
      cpu.cyc(16'hCC00, MRD, 8'h00);
      chk("refresh_lost", 0, grant);
      cpu.idle();
      chk("refresh_ok", 1, grant);
      axi_rd(pdr_pkg::REG_STATUS);
      chk("status", 32'hA0, rd);
      axi_rd(pdr_pkg::REG_IRQ_STAT);
      chk("irq_events", 32'hA, rd);
      $display("test misc done");
      complete_run();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      complete_run();
   end
endmodule // tb_pdr_router
`default_nettype wire
